// >>> verilog/fpas_pkg.sv
package fpas_pkg;
    localparam logic [3:0] FPAS_OFF_STATUS = 4'h0;
    localparam logic [3:0] FPAS_OFF_COND = 4'h4;
    localparam int FPAS_RM_LSB = 0;
    localparam int FPAS_INV_EN_BIT = 7;
    localparam int FPAS_CLASS_LSB = 12;
    localparam int FPAS_OVF_BIT = 28;
    localparam int FPAS_INV_BIT = 29;
    localparam int FPAS_ENX_BIT = 30;
    localparam int FPAS_SUM_BIT = 31;
    localparam int FPAS_COND_FLD_LSB = 24;
    localparam logic [31:0] FPAS_STATUS_RST = 32'h0000_0000;
    localparam logic [31:0] FPAS_COND_RST = 32'h0000_0000;
    localparam logic [31:0] FPAS_STATUS_WMASK = 32'hf000_0083;
    localparam logic [1:0] FPAS_RESP_OKAY = 2'h0;
    localparam logic [1:0] FPAS_RESP_SLVERR = 2'h2;
    localparam logic [10:0] FPAS_EXP_MAX = 11'h7ff;
    localparam logic [10:0] FPAS_SGL_EMAX = 11'h47e;
    localparam logic [10:0] FPAS_SGL_EMIN = 11'h381;
    localparam logic [63:0] FPAS_QNAN = 64'h7ff8_0000_0000_0000;
    localparam logic [63:0] FPAS_QUIET_BIT = 64'h0008_0000_0000_0000;
    localparam logic [4:0] FPAS_CLS_QNAN = 5'h11;
    localparam logic [4:0] FPAS_CLS_NINF = 5'h09;
    localparam logic [4:0] FPAS_CLS_NNORM = 5'h08;
    localparam logic [4:0] FPAS_CLS_NDEN = 5'h18;
    localparam logic [4:0] FPAS_CLS_NZERO = 5'h12;
    localparam logic [4:0] FPAS_CLS_PZERO = 5'h02;
    localparam logic [4:0] FPAS_CLS_PDEN = 5'h14;
    localparam logic [4:0] FPAS_CLS_PNORM = 5'h04;
    localparam logic [4:0] FPAS_CLS_PINF = 5'h05;

    typedef enum logic [1:0] {
        FPAS_OP_ADDS = 2'b00,
        FPAS_OP_SUB = 2'b01,
        FPAS_OP_SUBS = 2'b10
    } fpas_op_e;

    typedef enum logic [1:0] {
        FPAS_IDLE = 2'b00,
        FPAS_READ = 2'b01,
        FPAS_EXEC = 2'b10
    } fpas_state_e;

    typedef struct packed {
        fpas_op_e op;
        logic record;
        logic [4:0] dst;
        logic [4:0] srca;
        logic [4:0] srcb;
    } fpas_instr_s;

    typedef struct packed {
        logic [63:0] value;
        logic [4:0] result_class_flags;
        logic invalid;
        logic overflow;
    } fpas_result_s;
endpackage

// >>> verilog/fpas_add_core.sv
`timescale 1ns/1ps
module fpas_add_core (
    input wire logic [63:0] op_a,
    input wire logic [63:0] op_b,
    input wire logic sub,
    input wire logic single,
    input wire logic [1:0] rmode,
    output fpas_pkg::fpas_result_s res
);
    import fpas_pkg::*;

    logic sb, swap, sl, ss, esub, stk, grd, rst, lsb, rup, fnd, ovf, tomax, uflo;
    logic nan_a, nan_b, inf_a, inf_b, inv;
    logic [10:0] ea, eb, el, es, d;
    logic [55:0] ma, mb, ml, ms, msh, s56, nrm, unit, rnd56;
    logic [56:0] sum, rnd;
    logic [12:0] ex;
    logic [5:0] lz, sh;
    logic [63:0] v, vmax;

    always_comb
    begin
        sb = op_b[63] ^ sub;
        nan_a = (op_a[62:52] == FPAS_EXP_MAX) && (op_a[51:0] != 52'h0);
        nan_b = (op_b[62:52] == FPAS_EXP_MAX) && (op_b[51:0] != 52'h0);
        inf_a = (op_a[62:52] == FPAS_EXP_MAX) && (op_a[51:0] == 52'h0);
        inf_b = (op_b[62:52] == FPAS_EXP_MAX) && (op_b[51:0] == 52'h0);
        inv = inf_a && inf_b && (op_a[63] != sb);
        ea = (op_a[62:52] == 11'h0) ? 11'h1 : op_a[62:52];
        eb = (op_b[62:52] == 11'h0) ? 11'h1 : op_b[62:52];
        ma = {op_a[62:52] != 11'h0, op_a[51:0], 3'h0};
        mb = {op_b[62:52] != 11'h0, op_b[51:0], 3'h0};
        // Larger magnitude leads, smaller one is aligned to it
        swap = op_b[62:0] > op_a[62:0];
        sl = swap ? sb : op_a[63];
        ss = swap ? op_a[63] : sb;
        el = swap ? eb : ea;
        es = swap ? ea : eb;
        ml = swap ? mb : ma;
        ms = swap ? ma : mb;
        d = el - es;
        msh = (d > 11'd55) ? 56'h0 : ms >> d;
        stk = (d > 11'd55) ? |ms : |(ms & ~({56{1'b1}} << d));
        msh[0] = msh[0] | stk;
        esub = sl ^ ss;
        sum = esub ? {1'b0, ml} - {1'b0, msh} : {1'b0, ml} + {1'b0, msh};
        s56 = sum[56] ? {sum[56:2], sum[1] | sum[0]} : sum[55:0];
        ex = {2'b0, el} + {12'h0, sum[56]};
        lz = 6'h0;
        fnd = 1'b0;
        for (int i = 55; i >= 0; i--)
        begin
            fnd = fnd | s56[i];
            lz = lz + {5'h0, !fnd};
        end
        // Left shift stops at the smallest exponent, leaving a denormal
        sh = (ex > {7'h0, lz}) ? lz : 6'(ex - 13'h1);
        nrm = s56 << sh;
        ex = ex - {7'h0, sh};
        unit = single ? 56'h1_0000_0000 : 56'h8;
        grd = single ? nrm[31] : nrm[2];
        rst = single ? |nrm[30:0] : |nrm[1:0];
        lsb = single ? nrm[32] : nrm[3];
        rup = (rmode == 2'h0) ? grd & (rst | lsb) :
              (rmode == 2'h2) ? !sl & (grd | rst) :
              (rmode == 2'h3) ? sl & (grd | rst) : 1'b0;
        rnd = {1'b0, nrm & ~(unit - 56'h1)} + {1'b0, rup ? unit : 56'h0};
        rnd56 = rnd[56] ? rnd[56:1] : rnd[55:0];
        ex = ex + {12'h0, rnd[56]};
        ovf = single ? (ex > {2'b0, FPAS_SGL_EMAX}) : (ex >= {2'b0, FPAS_EXP_MAX});
        uflo = single && ((ex < {2'b0, FPAS_SGL_EMIN}) || !rnd56[55]);
        tomax = (rmode == 2'h1) || ((rmode == 2'h2) && sl) || ((rmode == 2'h3) && !sl);
        vmax = single ? {sl, FPAS_SGL_EMAX, 23'h7f_ffff, 29'h0} : {sl, 11'h7fe, 52'hf_ffff_ffff_ffff};
        v = {sl, rnd56[55] ? ex[10:0] : 11'h0, rnd56[54:3]};
        v = uflo ? {sl, 63'h0} : v;
        v = ovf ? (tomax ? vmax : {sl, FPAS_EXP_MAX, 52'h0}) : v;
        v = (s56 == 56'h0) ? {esub ? (rmode == 2'h3) : sl, 63'h0} : v;
        v = inf_b ? {sb, op_b[62:0]} : v;
        v = inf_a ? op_a : v;
        v = inv ? FPAS_QNAN : v;
        v = nan_b ? (op_b | FPAS_QUIET_BIT) : v;
        v = nan_a ? (op_a | FPAS_QUIET_BIT) : v;
        v = single ? {v[63:29], 29'h0} : v;
        res.value = v;
        res.invalid = inv && !nan_a && !nan_b;
        res.overflow = ovf && !nan_a && !nan_b && !inf_a && !inf_b && (s56 != 56'h0);
        res.result_class_flags = (v[62:52] == FPAS_EXP_MAX) ?
                   ((v[51:0] != 52'h0) ? FPAS_CLS_QNAN : (v[63] ? FPAS_CLS_NINF : FPAS_CLS_PINF)) :
                   (v[62:52] == 11'h0) ?
                   ((v[51:0] == 52'h0) ? (v[63] ? FPAS_CLS_NZERO : FPAS_CLS_PZERO) :
                   (v[63] ? FPAS_CLS_NDEN : FPAS_CLS_PDEN)) :
                   (v[63] ? FPAS_CLS_NNORM : FPAS_CLS_PNORM);
    end
endmodule // fpas_add_core

// >>> verilog/fpas_unit.sv
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module fpas_unit (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic instr_valid,
    input wire fpas_pkg::fpas_instr_s instr,
    output logic instr_ready,
    output logic [4:0] rf_raddr_a,
    output logic [4:0] rf_raddr_b,
    input wire logic [63:0] rf_rdata_a,
    input wire logic [63:0] rf_rdata_b,
    output logic rf_we,
    output logic [4:0] rf_waddr,
    output logic [63:0] rf_wdata,
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import fpas_pkg::*;

    fpas_state_e state_r, state_nxt;
    fpas_instr_s instr_r, instr_nxt;
    fpas_result_s res;
    logic [63:0] opa_r, opa_nxt, opb_r, opb_nxt, wdat_r, wdat_nxt;
    logic we_r, we_nxt;
    logic [31:0] status_r, status_nxt, cond_r, cond_nxt, bmask;
    logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [3:0] awaddr_r, awaddr_nxt, wstrb_r, wstrb_nxt;
    logic [31:0] wbuf_r, wbuf_nxt, rdata_r, rdata_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic single, sub, legal, inv_en, exec, wb_en, commit, st_wr, cond_wr;

    assign instr_ready = (state_r == FPAS_IDLE);
    assign rf_raddr_a = instr_r.srca;
    assign rf_raddr_b = instr_r.srcb;
    assign rf_waddr = instr_r.dst;
    assign rf_we = we_r;
    assign rf_wdata = wdat_r;
    assign single = (instr_r.op != FPAS_OP_SUB);
    assign sub = (instr_r.op != FPAS_OP_ADDS);
    assign legal = (instr_r.op == FPAS_OP_ADDS) || (instr_r.op == FPAS_OP_SUB) || (instr_r.op == FPAS_OP_SUBS);
    assign inv_en = status_r[FPAS_INV_EN_BIT];
    assign exec = (state_r == FPAS_EXEC);
    assign wb_en = exec && legal && !(res.invalid && inv_en);
    assign awready = !aw_got_r;
    assign wready = !w_got_r;
    assign arready = !rvalid_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign commit = aw_got_r && w_got_r && !bvalid_r;
    assign st_wr = commit && (awaddr_r == FPAS_OFF_STATUS);
    assign cond_wr = commit && (awaddr_r == FPAS_OFF_COND);
    assign bmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

    fpas_add_core u_core (
        .op_a(opa_r),
        .op_b(opb_r),
        .sub(sub),
        .single(single),
        .rmode(status_r[FPAS_RM_LSB +: 2]),
        .res(res)
    );

    // Issue, operand fetch and write-back sequence
    always_comb
    begin
        state_nxt = state_r;
        instr_nxt = instr_r;
        opa_nxt = opa_r;
        opb_nxt = opb_r;
        we_nxt = 1'b0;
        wdat_nxt = wdat_r;
        case (state_r)
            FPAS_IDLE:
            begin
                if (instr_valid)
                begin
                    instr_nxt = instr;
                    state_nxt = FPAS_READ;
                end
            end
            FPAS_READ:
            begin
                opa_nxt = rf_rdata_a;
                opb_nxt = rf_rdata_b;
                state_nxt = FPAS_EXEC;
            end
            FPAS_EXEC:
            begin
                we_nxt = wb_en;
                wdat_nxt = res.value;
                state_nxt = FPAS_IDLE;
            end
            default:
            begin
                state_nxt = FPAS_IDLE;
            end
        endcase
    end

    // Register slave channels
    always_comb
    begin
        aw_got_nxt = (aw_got_r && !commit) || (awvalid && !aw_got_r);
        awaddr_nxt = (awvalid && !aw_got_r) ? awaddr : awaddr_r;
        w_got_nxt = (w_got_r && !commit) || (wvalid && !w_got_r);
        wbuf_nxt = (wvalid && !w_got_r) ? wdata : wbuf_r;
        wstrb_nxt = (wvalid && !w_got_r) ? wstrb : wstrb_r;
        bvalid_nxt = commit || (bvalid_r && !bready);
        bresp_nxt = bresp_r;
        if (commit)
        begin
            bresp_nxt = (st_wr || cond_wr) ? FPAS_RESP_OKAY : FPAS_RESP_SLVERR;
        end
        rvalid_nxt = (arvalid && !rvalid_r) || (rvalid_r && !rready);
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (arvalid && !rvalid_r)
        begin
            rdata_nxt = (araddr == FPAS_OFF_STATUS) ? status_r : (araddr == FPAS_OFF_COND) ? cond_r : 32'h0;
            rresp_nxt = ((araddr == FPAS_OFF_STATUS) || (araddr == FPAS_OFF_COND)) ? FPAS_RESP_OKAY : FPAS_RESP_SLVERR;
        end
    end

    // Status and condition registers; hardware events win over software writes
    always_comb
    begin
        status_nxt = status_r;
        cond_nxt = cond_r;
        if (st_wr)
        begin
            status_nxt = (status_r & ~(FPAS_STATUS_WMASK & bmask)) | (wbuf_r & FPAS_STATUS_WMASK & bmask);
        end
        if (cond_wr)
        begin
            cond_nxt = (cond_r & ~bmask) | (wbuf_r & bmask);
        end
        if (exec && legal)
        begin
            if (!(res.invalid && inv_en))
            begin
                status_nxt[FPAS_CLASS_LSB +: 5] = res.result_class_flags;
            end
            status_nxt[FPAS_INV_BIT] = status_nxt[FPAS_INV_BIT] | res.invalid;
            status_nxt[FPAS_OVF_BIT] = status_nxt[FPAS_OVF_BIT] | res.overflow;
            status_nxt[FPAS_ENX_BIT] = status_nxt[FPAS_ENX_BIT] | (res.invalid && inv_en);
            status_nxt[FPAS_SUM_BIT] = status_nxt[FPAS_SUM_BIT] | res.invalid | res.overflow;
            if (instr_r.record)
            begin
                cond_nxt[FPAS_COND_FLD_LSB +: 4] = status_nxt[FPAS_OVF_BIT +: 4];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= FPAS_IDLE;
            instr_r <= '0;
            opa_r <= 64'h0;
            opb_r <= 64'h0;
            we_r <= 1'b0;
            wdat_r <= 64'h0;
            status_r <= FPAS_STATUS_RST;
            cond_r <= FPAS_COND_RST;
            aw_got_r <= 1'b0;
            awaddr_r <= 4'h0;
            w_got_r <= 1'b0;
            wbuf_r <= 32'h0;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= FPAS_RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= FPAS_RESP_OKAY;
        end
        else
        begin
            state_r <= state_nxt;
            instr_r <= instr_nxt;
            opa_r <= opa_nxt;
            opb_r <= opb_nxt;
            we_r <= we_nxt;
            wdat_r <= wdat_nxt;
            status_r <= status_nxt;
            cond_r <= cond_nxt;
            aw_got_r <= aw_got_nxt;
            awaddr_r <= awaddr_nxt;
            w_got_r <= w_got_nxt;
            wbuf_r <= wbuf_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_dest_write: assert property (wb_en |=> rf_we && rf_waddr == $past(instr_r.dst) && rf_wdata == $past(res.value))
        else $error("Result not written to destination");
    a_align_zero: assert property (exec && !single && opb_r[62:0] == 63'h0 && opa_r[62:52] != 11'h0
        && opa_r[62:52] != FPAS_EXP_MAX |-> res.value == opa_r)
        else $error("Operand changed by zero addend");
    a_sticky_trunc: assert property (exec && !single && status_r[1:0] == 2'h1 && !opa_r[63] && !opb_r[63]
        && opb_r[62:0] != 63'h0 && opa_r[51:0] != 52'h0 && opa_r[62:52] != FPAS_EXP_MAX
        && {1'b0, opa_r[62:52]} > {1'b0, opb_r[62:52]} + 12'd60 |-> res.value == opa_r - 64'h1)
        else $error("Sticky bit lost in truncation");
    a_carry_shift: assert property (exec && !single && opb_r == {!opa_r[63], opa_r[62:0]} && opa_r[62:52] != 11'h0
        && opa_r[62:52] < 11'h7fe |-> res.value == {opa_r[63], opa_r[62:52] + 11'h1, opa_r[51:0]})
        else $error("Carry out not handled");
    a_norm_shift: assert property (exec && !single && !opa_r[63] && !opb_r[63] && opa_r[51:0] == 52'h8_0000_0000_0000
        && opb_r[51:0] == 52'h0 && opa_r[62:52] == opb_r[62:52] && opa_r[62:52] > 11'h1
        && opa_r[62:52] != FPAS_EXP_MAX |-> res.value == {1'b0, opa_r[62:52] - 11'h1, 52'h0})
        else $error("Result not normalized");
    a_round_single: assert property (exec && single && status_r[1:0] == 2'h1 && opb_r[62:0] == 63'h0 && !opa_r[63]
        && opa_r[62:52] >= FPAS_SGL_EMIN && opa_r[62:52] <= FPAS_SGL_EMAX |-> res.value == {opa_r[63:29], 29'h0})
        else $error("Wrong rounding toward zero");
    a_sub_self: assert property (exec && sub && opa_r == opb_r && opa_r[62:52] != FPAS_EXP_MAX
        |-> res.value[62:0] == 63'h0)
        else $error("Self subtraction not zero");
    a_class_upd: assert property (wb_en |=> status_r[FPAS_CLASS_LSB +: 5] == $past(res.result_class_flags))
        else $error("Class flags not updated");
    a_class_hold: assert property (exec && res.invalid && inv_en |=> $stable(status_r[FPAS_CLASS_LSB +: 5]))
        else $error("Class flags changed on enabled invalid");
    a_cond_rec: assert property (exec && legal && instr_r.record |=>
        cond_r[FPAS_COND_FLD_LSB +: 4] == status_r[FPAS_OVF_BIT +: 4])
        else $error("Condition field not copied");
    a_cond_plain: assert property (exec && !instr_r.record && !cond_wr |=> $stable(cond_r))
        else $error("Condition register changed by plain form");
    a_issue_fetch: assert property (instr_valid && instr_ready |=> state_r == FPAS_READ
        && rf_raddr_a == $past(instr.srca) && rf_raddr_b == $past(instr.srcb) ##1 state_r == FPAS_EXEC)
        else $error("Source specifiers not used");
    a_single_fmt: assert property (exec && single |-> res.value[28:0] == 29'h0)
        else $error("Single result carries double bits");
endmodule // fpas_unit

// >>> tb/fpas_rf_model.sv
`timescale 1ns/1ps
module fpas_rf_model (
    input wire logic aclk,
    input wire logic [4:0] rf_raddr_a,
    input wire logic [4:0] rf_raddr_b,
    output logic [63:0] rf_rdata_a,
    output logic [63:0] rf_rdata_b,
    input wire logic rf_we,
    input wire logic [4:0] rf_waddr,
    input wire logic [63:0] rf_wdata,
    input wire logic load_en,
    input wire logic [4:0] load_addr,
    input wire logic [63:0] load_data
);
    logic [63:0] mem [32];
    // Asynchronous read of both source registers
    assign rf_rdata_a = mem[rf_raddr_a];
    assign rf_rdata_b = mem[rf_raddr_b];
    // Result write from the unit, preload from the bench when idle
    always_ff @(posedge aclk)
    begin
        if (rf_we)
            mem[rf_waddr] <= rf_wdata;
        else if (load_en)
            mem[load_addr] <= load_data;
    end
endmodule // fpas_rf_model

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import fpas_pkg::*;
    logic aclk, aresetn, instr_valid, instr_ready, rf_we, load_en;
    fpas_instr_s instr;
    logic [4:0] rf_raddr_a, rf_raddr_b, rf_waddr, load_addr;
    logic [63:0] rf_rdata_a, rf_rdata_b, rf_wdata, load_data, va, vb;
    logic [3:0] awaddr, wstrb, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rr;
    int error_cnt, compares, cycles, seed, k;
    fpas_op_e o;
    logic [63:0] rnd_exp [8] = '{64'h3ff0_0000_0000_0000, 64'h3ff0_0000_0000_0000, 64'h3ff0_0000_0000_0001,
        64'h3ff0_0000_0000_0000, 64'h3ff0_0000_0000_0000, 64'h3ff0_0000_0000_0000, 64'h3ff0_0000_2000_0000,
        64'h3ff0_0000_0000_0000};

    fpas_unit fpas_unit_inst (.aclk, .aresetn, .instr_valid, .instr, .instr_ready, .rf_raddr_a, .rf_raddr_b,
        .rf_rdata_a, .rf_rdata_b, .rf_we, .rf_waddr, .rf_wdata, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    fpas_rf_model fpas_rf_model_inst (.aclk, .rf_raddr_a, .rf_raddr_b, .rf_rdata_a, .rf_rdata_b, .rf_we,
        .rf_waddr, .rf_wdata, .load_en, .load_addr, .load_data);

    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic end_sim;
        $display("Errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [63:0] dbl(input int i);
        return $realtobits(real'(i));
    endfunction

    function automatic logic [63:0] exp_val(input fpas_op_e op, input logic [63:0] a, input logic [63:0] b);
        real r;
        shortreal s;
        r = (op == FPAS_OP_ADDS) ? $bitstoreal(a) + $bitstoreal(b) : $bitstoreal(a) - $bitstoreal(b);
        s = r;
        return (op == FPAS_OP_SUB) ? $realtobits(r) : $realtobits(real'(s));
    endfunction

    function automatic logic [4:0] cls(input logic [63:0] v);
        if (v[62:52] == 11'h7ff)
            return FPAS_CLS_QNAN;
        if (v[62:0] == 63'h0)
            return v[63] ? FPAS_CLS_NZERO : FPAS_CLS_PZERO;
        return v[63] ? FPAS_CLS_NNORM : FPAS_CLS_PNORM;
    endfunction

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            aw_ok = aw_ok | awready;
            w_ok = w_ok | wready;
            if (aw_ok)
                awvalid <= 1'b0;
            if (w_ok)
                wvalid <= 1'b0;
        end
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Preload both sources, issue, then check latency, specifiers, result and class
    task automatic run_op(input fpas_op_e op, input logic rec, input logic wr, input logic [63:0] x,
        input logic [63:0] y, input logic [63:0] e);
        int n;
        logic [4:0] d, a, b;
        d = 5'($random(seed));
        a = 5'($random(seed));
        b = a ^ 5'h01;
        load_en <= 1'b1;
        load_addr <= a;
        load_data <= x;
        @(posedge aclk);
        load_addr <= b;
        load_data <= y;
        @(posedge aclk);
        load_en <= 1'b0;
        instr <= '{op: op, record: rec, dst: d, srca: a, srcb: b};
        instr_valid <= 1'b1;
        do @(posedge aclk); while (instr_ready !== 1'b1);
        instr_valid <= 1'b0;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (n == 1)
            begin
                chk(64'(rf_raddr_a), 64'(a), "first source");
                chk(64'(rf_raddr_b), 64'(b), "second source");
            end
        end while (rf_we !== 1'b1 && n < 8);
        if (wr)
        begin
            chk(64'(n), 64'd3, "latency");
            chk(64'(rf_waddr), 64'(d), "destination");
            chk(rf_wdata, e, "result");
        end
        else
            chk(64'(n), 64'd8, "no write");
        axi_rd(FPAS_OFF_STATUS, rd, rr);
        chk(64'(rd[16:12]), 64'(cls(e)), "class");
    endtask

    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    initial
    begin
        seed = 63;
        {error_cnt, compares, cycles} = '0;
        {aresetn, instr_valid, awvalid, wvalid, bready, arvalid, rready, load_en} = '0;
        {instr, awaddr, araddr, wdata, load_addr, load_data} = '0;
        wstrb = 4'hf;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(FPAS_OFF_STATUS, rd, rr);
        chk(64'(rd), 64'(FPAS_STATUS_RST), "status reset");
        axi_rd(FPAS_OFF_COND, rd, rr);
        chk(64'(rd), 64'(FPAS_COND_RST), "cond reset");
        axi_rd(4'h8, rd, rr);
        chk({rd, 30'h0, rr}, {32'h0, 30'h0, FPAS_RESP_SLVERR}, "unmapped read");
        axi_wr(4'hc, 32'hffff_ffff, rr);
        chk(64'(rr), 64'(FPAS_RESP_SLVERR), "unmapped write");
        axi_wr(FPAS_OFF_COND, 32'h1234_5678, rr);
        repeat (14)
        begin
            va = dbl($random(seed) % 1000);
            vb = dbl($random(seed) % 1000);
            k = $unsigned($random(seed)) % 3;
            o = fpas_op_e'(2'(k));
            run_op(o, 1'b0, 1'b1, va, vb, exp_val(o, va, vb));
        end
        run_op(FPAS_OP_SUB, 1'b0, 1'b1, dbl(5), dbl(5), 64'h0);
        axi_rd(FPAS_OFF_COND, rd, rr);
        chk(64'(rd), 64'h1234_5678, "plain keeps cond");
        wstrb <= 4'h2;
        axi_wr(FPAS_OFF_COND, 32'hffff_56ff, rr);
        wstrb <= 4'hf;
        axi_rd(FPAS_OFF_COND, rd, rr);
        chk(64'(rd), 64'h1234_5678, "byte strobe");
        for (int i = 0; i < 8; i++)
        begin
            axi_wr(FPAS_OFF_STATUS, 32'(i % 4), rr);
            run_op(i < 4 ? FPAS_OP_SUB : FPAS_OP_SUBS, 1'b0, 1'b1, 64'h3ff0_0000_0000_0000,
                i < 4 ? 64'hbc30_0000_0000_0000 : 64'hbe10_0000_0000_0000, rnd_exp[i]);
        end
        axi_wr(FPAS_OFF_STATUS, 32'h1, rr);
        run_op(FPAS_OP_SUB, 1'b0, 1'b1, 64'h3ff8_0000_0000_0000, 64'h3b90_0000_0000_0000,
            64'h3ff7_ffff_ffff_ffff);
        axi_wr(FPAS_OFF_STATUS, 32'h0, rr);
        run_op(FPAS_OP_SUB, 1'b1, 1'b1, 64'h7ff0_0000_0000_0000, 64'h7ff0_0000_0000_0000, FPAS_QNAN);
        axi_rd(FPAS_OFF_COND, rd, rr);
        chk(64'(rd), 64'h1a34_5678, "record updates cond");
        axi_wr(FPAS_OFF_STATUS, 32'h0000_0080, rr);
        run_op(FPAS_OP_SUB, 1'b0, 1'b1, dbl(3), dbl(1), dbl(2));
        run_op(FPAS_OP_SUB, 1'b0, 1'b1, dbl(3), dbl(-3), dbl(6));
        run_op(FPAS_OP_SUB, 1'b0, 1'b1, dbl(3), dbl(2), dbl(1));
        run_op(FPAS_OP_SUB, 1'b0, 1'b0, 64'h7ff0_0000_0000_0000, 64'h7ff0_0000_0000_0000, dbl(2));
        run_op(fpas_op_e'(2'b11), 1'b0, 1'b0, dbl(7), dbl(1), dbl(2));
        end_sim();
    end
endmodule // testbench
